// [rtl/mfa_unit.sv]
`timescale 1ns/1ns
`default_nettype none
module mfa_unit #(
  parameter int BIT0_CYC = mfa_pkg::BIT_CYC0,
  parameter int BIT1_CYC = mfa_pkg::BIT_CYC1,
  parameter int BIT2_CYC = mfa_pkg::BIT_CYC2
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  mfa_bus_if.dev bus
);
  typedef struct packed {
    mfa_pkg::mfa_st_t st;
    logic [2:0] fld;
    logic [3:0] cnt;
    logic [11:0] sh;
    logic [11:0] rx;
    logic par;
    logic tx;
    logic bc;
    logic acc;
    logic perr;
    logic oe;
    logic [8:0] nrem;
    logic [7:0] idx;
    logic [1:0] retry;
    logic pend;
    logic lostf;
    logic [1:0] mode;
    logic wbc;
    logic [11:0] own;
    logic [11:0] dst;
    logic [3:0] ctl;
    logic [7:0] len;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [11:0] rxma;
    logic [11:0] rxsrc;
    logic [7:0] rxcnt;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } mfa_dev_t;

  mfa_dev_t r;
  mfa_dev_t n;
  logic [7:0] txbuf [0:mfa_pkg::BUF_N-1];
  logic [7:0] rxbuf [0:mfa_pkg::BUF_N-1];
  logic tick;
  logic b;
  logic pe;
  logic req;
  logic busy;
  logic rxwe;
  logic txwe;
  logic [3:0] ev;
  logic [31:0] wm;
  logic [31:0] nv;
  logic [31:0] rdv;
  logic [6:0] bi;
  logic [mfa_pkg::DIV_W-1:0] per;

  // speed follows the mode register; changing it mid-frame breaks the frame
  assign per = (r.mode == 2'h1) ? mfa_pkg::DIV_W'(BIT1_CYC) :
               (r.mode == 2'h2) ? mfa_pkg::DIV_W'(BIT2_CYC) : mfa_pkg::DIV_W'(BIT0_CYC);

  mfa_tick #(.W(mfa_pkg::DIV_W)) u_tick (
    .clock(clock),
    .nrst(nrst),
    .per(per),
    .tick(tick)
  );

  always_comb begin
    n = r;
    ev = 4'h0;
    rxwe = 1'b0;
    txwe = 1'b0;
    rdv = 32'h0000_0000;
    nv = 32'h0000_0000;
    b = bus.bus_lvl;
    pe = (b != r.par);
    req = wb_cyc_i && wb_stb_i && !r.ack;
    busy = r.pend || (r.st != mfa_pkg::S_IDLE);
    wm = mfa_pkg::byte_mask(wb_sel_i);
    bi = wb_adr_i[8:2];
    n.ack = req;
    if (tick) begin
      case (r.st)
        mfa_pkg::S_IDLE: begin
          if (r.lostf) begin
            n.lostf = 1'b0;
            if (r.retry == mfa_pkg::MAX_RETRY) begin
              n.pend = 1'b0;
              ev[mfa_pkg::EV_LOST] = 1'b1;
            end else begin
              n.retry = r.retry + 2'h1;
            end
          end
          // a start already on the line turns us into a receiver
          if (!b) begin
            n.st = mfa_pkg::S_BC;
            n.tx = 1'b0;
          end else if (r.pend && !r.lostf) begin
            n.st = mfa_pkg::S_SB;
            n.tx = 1'b1;
          end
        end
        mfa_pkg::S_SB: begin
          n.st = mfa_pkg::S_BC;
        end
        mfa_pkg::S_BC: begin
          n.bc = (b == mfa_pkg::BIT_BCAST);
          if (r.tx && !r.wbc && n.bc) begin
            n.tx = 1'b0;
            n.lostf = 1'b1;
          end
          n.st = mfa_pkg::S_FLD;
          n.fld = mfa_pkg::F_MA;
          n.cnt = mfa_pkg::fld_top(mfa_pkg::F_MA);
          n.sh = r.own;
          n.par = 1'b0;
          n.acc = 1'b0;
          n.perr = 1'b0;
          n.idx = 8'h00;
        end
        mfa_pkg::S_FLD: begin
          n.rx = {r.rx[10:0], b};
          n.par = r.par ^ b;
          n.sh = {r.sh[10:0], 1'b0};
          if (r.tx && r.fld == mfa_pkg::F_MA && r.sh[11] && !b) begin
            n.tx = 1'b0;
            n.lostf = 1'b1;
          end
          if (r.cnt == 4'h0) begin
            n.st = mfa_pkg::S_PAR;
          end else begin
            n.cnt = r.cnt - 4'h1;
          end
        end
        mfa_pkg::S_PAR: begin
          n.st = mfa_pkg::S_ACK;
          n.par = 1'b0;
          if (pe) begin
            n.acc = 1'b0;
          end
          case (r.fld)
            mfa_pkg::F_MA: begin
              // master address field alone has no acknowledge slot
              n.rxma = r.rx;
              n.perr = pe;
              n.st = mfa_pkg::S_FLD;
              n.fld = mfa_pkg::F_SA;
              n.cnt = mfa_pkg::fld_top(mfa_pkg::F_SA);
              n.sh = r.dst;
            end
            mfa_pkg::F_SA: begin
              n.acc = !r.tx && !pe && !r.perr && mfa_pkg::addr_hit(r.bc, r.rx, r.own);
              if (n.acc) begin
                n.rxcnt = 8'h00;
              end
            end
            mfa_pkg::F_LEN: begin
              n.nrem = mfa_pkg::frame_bytes(r.rx[7:0], r.mode);
            end
            mfa_pkg::F_DAT: begin
              if (r.acc && !pe) begin
                rxwe = 1'b1;
                n.rxcnt = r.rxcnt + 8'h01;
              end
            end
            default: begin
            end
          endcase
        end
        mfa_pkg::S_ACK: begin
          if (!r.bc && b != mfa_pkg::ACK_VAL) begin
            n.st = mfa_pkg::S_IDLE;
            n.acc = 1'b0;
            if (r.tx) begin
              n.tx = 1'b0;
              n.pend = 1'b0;
              ev[mfa_pkg::EV_NAK] = 1'b1;
            end
          end else begin
            n.st = mfa_pkg::S_FLD;
            n.fld = (r.fld == mfa_pkg::F_DAT) ? mfa_pkg::F_DAT : r.fld + 3'h1;
            n.nrem = (r.fld == mfa_pkg::F_DAT) ? r.nrem - 9'h001 : r.nrem;
            n.cnt = mfa_pkg::fld_top(n.fld);
            n.sh = mfa_pkg::fld_load(n.fld, r.dst, r.ctl, r.len, txbuf[r.idx[6:0]]);
            if (n.fld == mfa_pkg::F_DAT) begin
              n.idx = r.idx + 8'h01;
            end
            if (r.fld == mfa_pkg::F_DAT && n.nrem == 9'h000) begin
              n.st = mfa_pkg::S_IDLE;
              n.acc = 1'b0;
              if (r.tx) begin
                n.tx = 1'b0;
                n.pend = 1'b0;
                ev[mfa_pkg::EV_DONE] = 1'b1;
              end else if (r.acc) begin
                n.rxsrc = r.rxma;
                ev[mfa_pkg::EV_RX] = 1'b1;
              end
            end
          end
        end
        default: begin
          n.st = mfa_pkg::S_IDLE;
        end
      endcase
      // drive for the slot that opens now; oe pulls the line low
      case (n.st)
        mfa_pkg::S_SB: n.oe = 1'b1;
        mfa_pkg::S_BC: n.oe = n.tx && r.wbc;
        mfa_pkg::S_FLD: n.oe = n.tx && !n.sh[11];
        mfa_pkg::S_PAR: n.oe = n.tx && !n.par;
        mfa_pkg::S_ACK: n.oe = !n.tx && n.acc && !n.bc;
        default: n.oe = 1'b0;
      endcase
    end
    case (wb_adr_i)
      mfa_pkg::R_CTRL: rdv = {28'h000_0000, r.wbc, r.mode, busy};
      mfa_pkg::R_OWN: rdv = {20'h0_0000, r.own};
      mfa_pkg::R_DST: rdv = {20'h0_0000, r.dst};
      mfa_pkg::R_CTLLEN: rdv = {16'h0000, r.len, 4'h0, r.ctl};
      mfa_pkg::R_STAT: rdv = {28'h000_0000, r.stat};
      mfa_pkg::R_MASK: rdv = {28'h000_0000, r.mask};
      mfa_pkg::R_INFO: rdv = {8'h00, r.rxcnt, 2'h0, r.retry, r.rxsrc};
      default: begin
        if (wb_adr_i[11:10] == mfa_pkg::BANK_TX) begin
          rdv = {24'h00_0000, txbuf[bi]};
        end else if (wb_adr_i[11:10] == mfa_pkg::BANK_RX) begin
          rdv = {24'h00_0000, rxbuf[bi]};
        end
      end
    endcase
    nv = (rdv & ~wm) | (wb_dat_i & wm);
    n.dat = (req && !wb_we_i) ? rdv : 32'h0000_0000;
    if (req && wb_we_i) begin
      case (wb_adr_i)
        mfa_pkg::R_CTRL: begin
          n.wbc = nv[mfa_pkg::CTRL_BC];
          n.mode = nv[mfa_pkg::CTRL_MODE+:2];
          // a start request while busy is dropped
          if (nv[mfa_pkg::CTRL_GO] && wm[mfa_pkg::CTRL_GO] && !busy) begin
            n.pend = 1'b1;
            n.retry = 2'h0;
          end
        end
        mfa_pkg::R_OWN: n.own = nv[11:0];
        mfa_pkg::R_DST: n.dst = nv[11:0];
        mfa_pkg::R_CTLLEN: begin
          n.ctl = nv[3:0];
          n.len = nv[15:8];
        end
        mfa_pkg::R_MASK: n.mask = nv[3:0];
        default: txwe = (wb_adr_i[11:10] == mfa_pkg::BANK_TX) && wb_sel_i[0];
      endcase
    end
    // an event in the clearing read's cycle survives
    n.stat = ((req && !wb_we_i && wb_adr_i == mfa_pkg::R_STAT) ? 4'h0 : r.stat) | ev;
    n.irq = |(n.stat & n.mask);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '{st: mfa_pkg::S_IDLE, default: '0};
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clock) begin
    if (txwe) begin
      txbuf[bi] <= wb_dat_i[7:0];
    end
    if (rxwe) begin
      rxbuf[r.rxcnt[6:0]] <= r.rx[7:0];
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign irq = r.irq;
  assign bus.dev_oe = r.oe;
  assign bus.dev_o = 1'b0;
endmodule // mfa_unit
`default_nettype wire

// [rtl/mfa_pkg.sv]
package mfa_pkg;
  localparam int CLK_MHZ = 250;
  // slot length per speed mode, one bus bit per slot
  localparam int BIT_NS0 = 256000;
  localparam int BIT_NS1 = 58000;
  localparam int BIT_NS2 = 38000;
  localparam int BIT_CYC0 = BIT_NS0 * CLK_MHZ / 1000;
  localparam int BIT_CYC1 = BIT_NS1 * CLK_MHZ / 1000;
  localparam int BIT_CYC2 = BIT_NS2 * CLK_MHZ / 1000;
  localparam int DIV_W = 20;
  localparam int BUF_N = 128;
  localparam logic [11:0] GEN_BCAST = 12'hfff;
  localparam logic BIT_BCAST = 1'b0;
  localparam logic ACK_VAL = 1'b0;
  localparam logic [1:0] MAX_RETRY = 2'h3;
  localparam logic [8:0] MAXB0 = 9'h010;
  localparam logic [8:0] MAXB1 = 9'h020;
  localparam logic [8:0] MAXB2 = 9'h080;
  localparam logic [2:0] F_MA = 3'h0;
  localparam logic [2:0] F_SA = 3'h1;
  localparam logic [2:0] F_CTL = 3'h2;
  localparam logic [2:0] F_LEN = 3'h3;
  localparam logic [2:0] F_DAT = 3'h4;
  localparam logic [11:0] R_CTRL = 12'h000;
  localparam logic [11:0] R_OWN = 12'h004;
  localparam logic [11:0] R_DST = 12'h008;
  localparam logic [11:0] R_CTLLEN = 12'h00c;
  localparam logic [11:0] R_STAT = 12'h010;
  localparam logic [11:0] R_MASK = 12'h014;
  localparam logic [11:0] R_INFO = 12'h018;
  localparam logic [1:0] BANK_TX = 2'h1;
  localparam logic [1:0] BANK_RX = 2'h2;
  localparam int CTRL_GO = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_BC = 3;
  localparam int EV_DONE = 0;
  localparam int EV_LOST = 1;
  localparam int EV_NAK = 2;
  localparam int EV_RX = 3;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_SB = 6'h02,
    S_BC = 6'h04,
    S_FLD = 6'h08,
    S_PAR = 6'h10,
    S_ACK = 6'h20
  } mfa_st_t;

  function automatic logic [3:0] fld_top(input logic [2:0] f);
    case (f)
      F_MA, F_SA: return 4'hb;
      F_CTL: return 4'h3;
      default: return 4'h7;
    endcase
  endfunction

  // fields go out msb first from bit 11 of the shifter
  function automatic logic [11:0] fld_load(input logic [2:0] f, input logic [11:0] sa,
      input logic [3:0] ctl, input logic [7:0] len, input logic [7:0] dat);
    case (f)
      F_SA: return sa;
      F_CTL: return {ctl, 8'h00};
      F_LEN: return {len, 4'h0};
      default: return {dat, 4'h0};
    endcase
  endfunction

  // length 00 means 256; mode 3 is treated as mode 0
  function automatic logic [8:0] frame_bytes(input logic [7:0] len, input logic [1:0] mode);
    logic [8:0] lim;
    logic [8:0] cnt;
    lim = (mode == 2'h1) ? MAXB1 : (mode == 2'h2) ? MAXB2 : MAXB0;
    cnt = (len == 8'h00) ? 9'h100 : {1'b0, len};
    return (cnt > lim) ? lim : cnt;
  endfunction

  function automatic logic addr_hit(input logic bc, input logic [11:0] sa,
      input logic [11:0] own);
    if (!bc) return sa == own;
    if (sa == GEN_BCAST) return 1'b1;
    return sa[11:8] == own[11:8];
  endfunction

  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction
endpackage

// [rtl/mfa_bus_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface mfa_bus_if;
  logic dev_o;
  logic dev_oe;
  logic far_o;
  logic far_oe;
  logic bus_lvl;
  // wired-and: a released line floats high
  assign bus_lvl = (dev_oe ? dev_o : 1'b1) & (far_oe ? far_o : 1'b1);
  modport dev (output dev_o, output dev_oe, input bus_lvl);
  modport far (output far_o, output far_oe, input bus_lvl);
endinterface // mfa_bus_if
`default_nettype wire

// [rtl/mfa_tick.sv]
`timescale 1ns/1ns
`default_nettype none
module mfa_tick #(
  parameter int W = 20
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] per,
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } mfa_tick_t;
  mfa_tick_t r;
  mfa_tick_t n;

  // a new period is picked up only at the next reload
  always_comb begin
    n = r;
    n.tick = (r.cnt == '0);
    n.cnt = n.tick ? per - W'(1) : r.cnt - W'(1);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;
endmodule // mfa_tick
`default_nettype wire

// [rtl/mfa_peer.sv]
`timescale 1ns/1ns
`default_nettype none
module mfa_peer #(
  parameter int BIT0_CYC = mfa_pkg::BIT_CYC0,
  parameter int BIT1_CYC = mfa_pkg::BIT_CYC1,
  parameter int BIT2_CYC = mfa_pkg::BIT_CYC2
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [11:0] own_addr,
  input wire logic [1:0] mode,
  input wire logic go,
  input wire logic want_bc,
  input wire logic [11:0] dst,
  input wire logic [3:0] ctl,
  input wire logic [7:0] len,
  input wire logic [7:0] tx_data,
  output logic tx_next,
  output logic [7:0] rx_data,
  output logic rx_stb,
  output logic busy,
  output logic done,
  output logic lost,
  output logic nak,
  mfa_bus_if.far bus
);
  typedef struct packed {
    mfa_pkg::mfa_st_t st;
    logic [2:0] fld;
    logic [3:0] cnt;
    logic [11:0] sh;
    logic [11:0] rx;
    logic par;
    logic tx;
    logic bc;
    logic acc;
    logic perr;
    logic oe;
    logic [8:0] nrem;
    logic pend;
    logic wbc;
    logic tx_next;
    logic [7:0] rx_data;
    logic rx_stb;
    logic busy;
    logic done;
    logic lost;
    logic nak;
  } mfa_peer_t;

  mfa_peer_t r;
  mfa_peer_t n;
  logic tick;
  logic b;
  logic pe;
  logic [mfa_pkg::DIV_W-1:0] per;

  // mode must match the device's before any frame; it is not latched
  assign per = (mode == 2'h1) ? mfa_pkg::DIV_W'(BIT1_CYC) :
               (mode == 2'h2) ? mfa_pkg::DIV_W'(BIT2_CYC) : mfa_pkg::DIV_W'(BIT0_CYC);

  mfa_tick #(.W(mfa_pkg::DIV_W)) u_tick (
    .clock(clock),
    .nrst(nrst),
    .per(per),
    .tick(tick)
  );

  always_comb begin
    n = r;
    n.tx_next = 1'b0;
    n.rx_stb = 1'b0;
    n.done = 1'b0;
    n.lost = 1'b0;
    n.nak = 1'b0;
    b = bus.bus_lvl;
    pe = (b != r.par);
    if (go && !r.pend && r.st == mfa_pkg::S_IDLE) begin
      n.pend = 1'b1;
      n.wbc = want_bc;
    end
    if (tick) begin
      case (r.st)
        mfa_pkg::S_IDLE: begin
          if (!b) begin
            n.st = mfa_pkg::S_BC;
            n.tx = 1'b0;
          end else if (r.pend) begin
            n.st = mfa_pkg::S_SB;
            n.tx = 1'b1;
          end
        end
        mfa_pkg::S_SB: n.st = mfa_pkg::S_BC;
        mfa_pkg::S_BC: begin
          n.bc = (b == mfa_pkg::BIT_BCAST);
          if (r.tx && !r.wbc && n.bc) begin
            n.tx = 1'b0;
            n.pend = 1'b0;
            n.lost = 1'b1;
          end
          n.st = mfa_pkg::S_FLD;
          n.fld = mfa_pkg::F_MA;
          n.cnt = mfa_pkg::fld_top(mfa_pkg::F_MA);
          n.sh = own_addr;
          n.par = 1'b0;
          n.acc = 1'b0;
          n.perr = 1'b0;
        end
        mfa_pkg::S_FLD: begin
          n.rx = {r.rx[10:0], b};
          n.par = r.par ^ b;
          n.sh = {r.sh[10:0], 1'b0};
          if (r.tx && r.fld == mfa_pkg::F_MA && r.sh[11] && !b) begin
            n.tx = 1'b0;
            n.pend = 1'b0;
            n.lost = 1'b1;
          end
          if (r.cnt == 4'h0) begin
            n.st = mfa_pkg::S_PAR;
          end else begin
            n.cnt = r.cnt - 4'h1;
          end
        end
        mfa_pkg::S_PAR: begin
          n.st = mfa_pkg::S_ACK;
          n.par = 1'b0;
          if (pe) begin
            n.acc = 1'b0;
          end
          case (r.fld)
            mfa_pkg::F_MA: begin
              n.perr = pe;
              n.st = mfa_pkg::S_FLD;
              n.fld = mfa_pkg::F_SA;
              n.cnt = mfa_pkg::fld_top(mfa_pkg::F_SA);
              n.sh = dst;
            end
            mfa_pkg::F_SA: n.acc = !r.tx && !pe && !r.perr && mfa_pkg::addr_hit(r.bc, r.rx, own_addr);
            mfa_pkg::F_LEN: n.nrem = mfa_pkg::frame_bytes(r.rx[7:0], mode);
            mfa_pkg::F_DAT: begin
              n.rx_stb = r.acc && !pe;
              n.rx_data = r.rx[7:0];
            end
            default: begin
            end
          endcase
        end
        mfa_pkg::S_ACK: begin
          if (!r.bc && b != mfa_pkg::ACK_VAL) begin
            n.st = mfa_pkg::S_IDLE;
            n.acc = 1'b0;
            n.nak = r.tx;
            n.pend = r.pend && !r.tx;
            n.tx = 1'b0;
          end else begin
            n.st = mfa_pkg::S_FLD;
            n.fld = (r.fld == mfa_pkg::F_DAT) ? mfa_pkg::F_DAT : r.fld + 3'h1;
            n.nrem = (r.fld == mfa_pkg::F_DAT) ? r.nrem - 9'h001 : r.nrem;
            n.cnt = mfa_pkg::fld_top(n.fld);
            n.sh = mfa_pkg::fld_load(n.fld, dst, ctl, len, tx_data);
            n.tx_next = r.tx && (n.fld == mfa_pkg::F_DAT);
            if (r.fld == mfa_pkg::F_DAT && n.nrem == 9'h000) begin
              n.st = mfa_pkg::S_IDLE;
              n.acc = 1'b0;
              n.done = r.tx;
              n.pend = r.pend && !r.tx;
              n.tx = 1'b0;
            end
          end
        end
        default: n.st = mfa_pkg::S_IDLE;
      endcase
      case (n.st)
        mfa_pkg::S_SB: n.oe = 1'b1;
        mfa_pkg::S_BC: n.oe = n.tx && r.wbc;
        mfa_pkg::S_FLD: n.oe = n.tx && !n.sh[11];
        mfa_pkg::S_PAR: n.oe = n.tx && !n.par;
        mfa_pkg::S_ACK: n.oe = !n.tx && n.acc && !n.bc;
        default: n.oe = 1'b0;
      endcase
    end
    n.busy = n.pend || (n.st != mfa_pkg::S_IDLE);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '{st: mfa_pkg::S_IDLE, default: '0};
    end else begin
      r <= n;
    end
  end

  assign tx_next = r.tx_next;
  assign rx_data = r.rx_data;
  assign rx_stb = r.rx_stb;
  assign busy = r.busy;
  assign done = r.done;
  assign lost = r.lost;
  assign nak = r.nak;
  assign bus.far_oe = r.oe;
  assign bus.far_o = 1'b0;
endmodule // mfa_peer
`default_nettype wire

// [test/mfa_bus_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module mfa_bus_monitor (
  input wire logic clock,
  input wire logic nrst,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic far_o,
  input wire logic far_oe,
  input wire logic bus_lvl
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // open drain only, so two ends driving at once never fight
  a_dev_pulls_low: assert property (dev_oe |-> !dev_o)
    else $error("device drives the line high");
  a_far_pulls_low: assert property (far_oe |-> !far_o)
    else $error("peer drives the line high");
  // bench runs 4-cycle slots; a shorter pulse means a slot was cut
  a_dev_rise_slot: assert property ($rose(dev_oe) |=> dev_oe [*3])
    else $error("device low slot cut short");
  a_dev_fall_slot: assert property ($fell(dev_oe) |=> !dev_oe [*3])
    else $error("device release slot cut short");
  a_far_rise_slot: assert property ($rose(far_oe) |=> far_oe [*3])
    else $error("peer low slot cut short");
  a_far_fall_slot: assert property ($fell(far_oe) |=> !far_oe [*3])
    else $error("peer release slot cut short");
  a_lvl_low_slot: assert property ($fell(bus_lvl) |=> !bus_lvl [*3])
    else $error("line low for less than a slot");
  a_lvl_high_slot: assert property ($rose(bus_lvl) |=> $stable(bus_lvl) [*3])
    else $error("line high for less than a slot");
endmodule // mfa_bus_monitor
`default_nettype wire

// [test/multimaster_frame_arbiter_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value %0t line %0d", $time, `__LINE__); end end
module multimaster_frame_arbiter_tb;
  logic clock = 0, nrst = 0, cyc = 0, we = 0, go = 0, pbc = 0, arm = 0, lvl_q = 1, plost = 0;
  logic [3:0] wsel = 4'hf, pctl = 4'h8;
  logic irq, ack, txn, rxs, busy, done, lost, nak, far_drove, dw;
  logic [11:0] adr = 0, pown = 0, pdst = 0, a, b;
  logic [31:0] wdat = 0, rdat, q, acc;
  logic [7:0] plen = 0, ln, rxd, pbuf [256], rxq [$];
  logic [1:0] pmode = 0, m;
  logic [8:0] pidx = 0;
  int bad_count = 0, total_checks = 0, seed = 32'h0000_19a0, k;
  // short slots keep frames cheap; both ends must share them
  localparam int SLOT = 4;
  time t_fall, t_rise, d_t, p_t;
  mfa_bus_if bus_if ();
  mfa_unit #(.BIT0_CYC(SLOT), .BIT1_CYC(SLOT), .BIT2_CYC(SLOT)) mfa_unit_inst (.clock(clock),
    .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .bus(bus_if));
  mfa_peer #(.BIT0_CYC(SLOT), .BIT1_CYC(SLOT), .BIT2_CYC(SLOT)) mfa_peer_inst (.clock(clock),
    .nrst(nrst), .own_addr(pown), .mode(pmode), .go(go), .want_bc(pbc), .dst(pdst),
    .ctl(pctl), .len(plen), .tx_data(pbuf[pidx[7:0]]), .tx_next(txn), .rx_data(rxd),
    .rx_stb(rxs), .busy(busy), .done(done), .lost(lost), .nak(nak), .bus(bus_if));
  mfa_bus_monitor mfa_bus_monitor_inst (.clock(clock), .nrst(nrst), .dev_o(bus_if.dev_o),
    .dev_oe(bus_if.dev_oe), .far_o(bus_if.far_o), .far_oe(bus_if.far_oe),
    .bus_lvl(bus_if.bus_lvl));
  always #2 clock = ~clock;
  // frame span is taken from the wire itself, first fall to last rise
  always @(posedge clock) begin
    lvl_q <= bus_if.bus_lvl;
    if (txn) pidx <= pidx + 9'h001;
    if (rxs) rxq.push_back(rxd);
    if (done) p_t = $time;
    if (irq && d_t == 0) d_t = $time;
    if (arm && bus_if.far_oe) far_drove = 1;
    if (arm && lost) plost = 1;
    if (arm && lvl_q && !bus_if.bus_lvl && t_fall == 0) t_fall = $time;
    if (arm && !lvl_q && bus_if.bus_lvl) t_rise = $time;
  end
  task automatic wb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    cyc <= 1;
    we <= w;
    adr <= ad;
    wdat <= d;
    // no answer time is assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    @(posedge clock);
  endtask
  task automatic poll(input logic [31:0] msk);
    acc = 0;
    for (int i = 0; i < 20000 && (acc & msk) == 0; i++) begin
      wb(0, mfa_pkg::R_STAT, 32'h0);
      acc |= q;
    end
  endtask
  task automatic dev_send(input logic bc, input logic [11:0] own, dst, input logic [7:0] l,
      input logic [1:0] md, input logic g);
    pmode <= md;
    pctl <= 4'($random(seed));
    wb(1, mfa_pkg::R_OWN, {20'h0, own});
    wb(1, mfa_pkg::R_DST, {20'h0, dst});
    wb(1, mfa_pkg::R_CTLLEN, {16'h0, l, 8'h08});
    for (int i = 0; i < 128; i++)
      wb(1, 12'h400 + 12'(4 * i), {24'h0, pbuf[i]});
    rxq = {};
    t_fall = 0;
    d_t = 0;
    p_t = 0;
    far_drove = 0;
    plost = 0;
    arm = 1;
    pidx <= 0;
    go <= g;
    wb(1, mfa_pkg::R_CTRL, {28'h0, bc, md, 1'b1});
    go <= 0;
  endtask
  function automatic int nb(input logic [7:0] l, input logic [1:0] md);
    int c;
    int cap;
    c = (l == 0) ? 256 : int'(l);
    cap = (md == 2) ? 128 : (16 << md);
    return (c > cap) ? cap : c;
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    finish_test();
  end
  initial begin
    for (k = 0; k < 256; k++)
      pbuf[k] = 8'($random(seed));
    repeat (12) @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    wb(0, 12'h01c, 32'h0);
    `CHK(q, 32'h0)
    wsel <= 4'h0;
    wb(1, mfa_pkg::R_MASK, 32'hf);
    wsel <= 4'hf;
    wb(0, mfa_pkg::R_MASK, 32'h0);
    `CHK(q, 32'h0)
    wb(1, mfa_pkg::R_MASK, 32'h1);
    for (k = 0; k < 4; k++) begin
      a = 12'($random(seed));
      ln = (k == 0) ? 8'h00 : 8'($random(seed));
      m = 2'(k % 3);
      pown <= a ^ 12'h801;
      dev_send(0, a, a ^ 12'h801, ln, m, 0);
      poll(32'h7);
      `CHK(acc[2:0], 3'h1)
      `CHK(rxq.size(), nb(ln, m))
      for (int i = 0; i < rxq.size(); i++)
        `CHK(rxq[i], pbuf[i])
      `CHK(t_rise - t_fall, time'((45 + 10 * nb(ln, m)) * 16))
      $display("test ordinary %0d done", k);
    end
    for (k = 0; k < 3; k++) begin
      a = (k == 0) ? 12'hfff : 12'($random(seed));
      b = (k == 0) ? 12'h000 : ~a;
      dw = (k != 2) && (a < b);
      pown <= b;
      pdst <= (k == 2) ? 12'hfff : a;
      pbc <= (k == 2);
      plen <= 8'h03;
      dev_send(0, a, b, 8'h04, 2'h1, 1);
      for (int i = 0; i < 20000 && ((p_t == 0 && !dw) || d_t == 0); i++)
        @(posedge clock);
      // a losing peer gives up, so its done never comes
      `CHK(plost, dw)
      `CHK(dw ? (p_t == 0) : (p_t != 0 && p_t < d_t), 1'b1)
      wb(0, mfa_pkg::R_INFO, 32'h0);
      `CHK(q[13:12], dw ? 2'h0 : 2'h1)
      if (!dw)
        `CHK(q[23:0], {8'h03, 2'h0, 2'h1, b})
      wb(0, mfa_pkg::R_STAT, 32'h0);
      `CHK(q[3:0], dw ? 4'h1 : 4'h9)
      if (!dw) begin
        wb(0, 12'h800, 32'h0);
        `CHK(q[7:0], pbuf[0])
      end
      @(posedge clock);
      `CHK(irq, 1'b0)
      $display("test arbitration %0d done", k);
    end
    pbc <= 0;
    pown <= 12'h000;
    // the peer keeps asking, so the device loses every contest
    dev_send(0, 12'hfff, 12'h000, 8'h04, 2'h1, 1);
    @(posedge clock);
    go <= 1;
    poll(32'h2);
    go <= 0;
    `CHK(acc[2:0], 3'h2)
    wb(0, mfa_pkg::R_INFO, 32'h0);
    `CHK(q[13:0], {2'h3, 12'h000})
    for (int i = 0; i < 5000 && busy; i++)
      @(posedge clock);
    $display("test retry limit done");
    for (k = 0; k < 3; k++) begin
      b = 12'($random(seed));
      a = (k == 0) ? 12'hfff : {b[11:8] ^ ((k == 2) ? 4'h1 : 4'h0), 8'h5a};
      pown <= b;
      dev_send(1, 12'h100, a, 8'h05, 2'h2, 0);
      poll(32'h7);
      `CHK(acc[2:0], 3'h1)
      `CHK(rxq.size(), (k == 2) ? 0 : 5)
      `CHK(far_drove, 1'b0)
      $display("test broadcast %0d done", k);
    end
    dev_send(0, 12'h010, ~b, 8'h02, 2'h0, 0);
    poll(32'h7);
    `CHK(acc[2:0], 3'h4)
    nrst <= 0;
    repeat (3) @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    wb(0, mfa_pkg::R_OWN, 32'h0);
    `CHK(q, 32'h0)
    $display("test nak and reset done");
    finish_test();
  end
endmodule // multimaster_frame_arbiter_tb
`default_nettype wire
